// *** hdl/isc_defs.svh ***
// Purpose: named constants of the inertial sample chain
// Assumes: 10 MHz system clock
// Notes: included by its bare name
`ifndef ISC_DEFS_SVH
`define ISC_DEFS_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define ISC_CLK_HZ 10000000
`define ISC_INT_RATE_HZ 4250
`define ISC_INT_DIV (`ISC_CLK_HZ / `ISC_INT_RATE_HZ)
`define ISC_GYRO_RATE_HZ 4100
`define ISC_GYRO_TOL_SPS 200
`define ISC_SECOND_GYRO_HZ 4000
`define ISC_SELF_TEST_MS 20
`define ISC_CYC_PER_MS (`ISC_CLK_HZ / 1000)
// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define ISC_IDX_IOFN 7'h00
`define ISC_IDX_CFG 7'h01
`define ISC_IDX_SCALE 7'h02
`define ISC_IDX_STATUS 7'h03
`define ISC_IDX_COUNT 7'h04
`define ISC_IDX_GYRO_X 7'h05
`define ISC_IDX_GYRO_Y 7'h06
`define ISC_IDX_GYRO_Z 7'h07
`define ISC_IDX_ACC_X 7'h08
`define ISC_IDX_ACC_Y 7'h09
`define ISC_IDX_ACC_Z 7'h0A
// ----------------------------------------
// fields, codes, reset values
// ----------------------------------------
`define ISC_IOFN_SEL_HI 7
`define ISC_IOFN_SEL_LO 4
`define ISC_CFG_LING 7
`define ISC_SEL_INTERNAL 4'h0
`define ISC_SEL_SYNC 4'h1
`define ISC_SEL_PPS 4'h2
`define ISC_IOFN_RST 16'h0000
`define ISC_CFG_RST 16'h0080
`define ISC_SCALE_RST 16'h0FA0
`define ISC_ZERO16 16'h0000
`define ISC_SPI_RW 15
`define ISC_SPI_LAST 4'hF
`define ISC_Q_ONE 16'h4000
`define ISC_Q_ZERO 16'h0000
`define ISC_LING_DEF 16'h0010
`define ISC_Q_SHIFT 14
`endif

// *** hdl/isc_pkg.sv ***
// Purpose: types of the inertial sample chain
// Assumes: nothing
// Notes: constants live in isc_defs.svh
package isc_pkg;
   typedef struct packed {
      logic signed [15:0] x;
      logic signed [15:0] y;
      logic signed [15:0] z;
   } axis3_t;
   typedef enum logic [0:0] {ST_TEST, ST_RUN} run_state_t;
endpackage : isc_pkg

// *** hdl/inertial_sample_chain.sv ***
// Purpose: sample master clock, gyro combining, factory correction, spi readout
// Assumes: converters deliver raw words on SYS_CLK; spi master keeps stall time between frames
// Notes: coefficients are constants, never readable
// Behaviour
// RULE_01 - self test first, then sampling starts
// RULE_02 - internal source ticks at 4250 per second
// RULE_03 - io function bits 7:4 select clock source
// RULE_04 - two free-running gyro samplers per axis
// RULE_05 - each tick averages latest two gyro samples
// RULE_06 - same tick captures all accelerometer axes
// RULE_07 - sync mode: each external edge ticks; here only rising edges of CONFIG_IO_LINE_1 tick
// RULE_08 - pulse mode: input rate times scale factor
// RULE_09 - gyro = M*raw + bias + G*accel
// RULE_10 - config bit 7 switches linear-g term
// RULE_11 - coefficients internal and never readable
// RULE_12 - dout changes on falling serial clock
// RULE_13 - din captured on rising serial clock
// RULE_14 - mode 3, 16-bit words, msb first
// RULE_15 - data only after read frame; idle released
// RULE_16 - outputs hold between sample ticks
`timescale 1ns/10ps
`include "isc_defs.svh"
module inertial_sample_chain #(
   parameter int SELF_TEST_CYCLES = `ISC_SELF_TEST_MS * `ISC_CYC_PER_MS,
   parameter int SECOND_GYRO_HZ = `ISC_SECOND_GYRO_HZ
) (
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   input wire logic WB_CYC,
   input wire logic WB_STB,
   input wire logic WB_WE,
   input wire logic [7:0] WB_ADR,
   input wire logic [3:0] WB_SEL,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK,
   input wire logic SPI_SCLK,
   input wire logic SPI_CS_N,
   input wire logic SPI_DIN,
   output logic SPI_DOUT,
   output logic SPI_DOUT_OE_N,
   input wire logic CONFIG_IO_LINE_1,
   input wire isc_pkg::axis3_t AXIS_GYRO_FIRST,
   input wire isc_pkg::axis3_t AXIS_GYRO_SECOND,
   input wire isc_pkg::axis3_t ACCEL_RAW,
   output isc_pkg::axis3_t GYRO_OUT,
   output isc_pkg::axis3_t ACCEL_OUT,
   output logic SAMPLE_MASTER_CLOCK,
   output logic SELF_TEST_DONE
);
   localparam int FIRST_DIV = `ISC_CLK_HZ / `ISC_GYRO_RATE_HZ;
   localparam int SECOND_DIV = `ISC_CLK_HZ / SECOND_GYRO_HZ;
   // ----------------------------------------
   // factory coefficients, no read path exists
   // ----------------------------------------
   localparam logic signed [15:0] GAIN_M [0:8] = '{`ISC_Q_ONE, `ISC_Q_ZERO, `ISC_Q_ZERO,
      `ISC_Q_ZERO, `ISC_Q_ONE, `ISC_Q_ZERO, `ISC_Q_ZERO, `ISC_Q_ZERO, `ISC_Q_ONE}; // RULE_11
   localparam logic signed [15:0] BIAS_B [0:2] = '{`ISC_Q_ZERO, `ISC_Q_ZERO, `ISC_Q_ZERO};
   localparam logic signed [15:0] LING_G [0:8] = '{`ISC_LING_DEF, `ISC_Q_ZERO, `ISC_Q_ZERO,
      `ISC_Q_ZERO, `ISC_LING_DEF, `ISC_Q_ZERO, `ISC_Q_ZERO, `ISC_Q_ZERO, `ISC_LING_DEF};
   // ----------------------------------------
   // state
   // ----------------------------------------
   isc_pkg::run_state_t run_state;
   logic [23:0] test_cnt;
   logic test_pass;
   logic [15:0] io_fn;
   logic [15:0] cfg;
   logic [15:0] sync_scale;
   logic [15:0] sample_count;
   logic [11:0] int_cnt;
   logic [11:0] g1_cnt;
   logic [11:0] g2_cnt;
   logic g1_seen;
   logic g2_seen;
   isc_pkg::axis3_t latest1;
   isc_pkg::axis3_t latest2;
   isc_pkg::axis3_t comb_q;
   isc_pkg::axis3_t acc_q;
   logic stage_v;
   logic ext_meta;
   logic ext_sync;
   logic ext_last;
   logic [23:0] pps_cnt;
   logic [23:0] pps_last;
   logic [24:0] pps_acc;
   logic tg_meta;
   logic tg_sync;
   logic tg_seen;
   logic [15:0] reply_word;
   logic reply_arm;
   logic [3:0] rx_cnt;
   logic [14:0] rx_shift;
   logic [15:0] frame;
   logic frame_tgl;
   logic [3:0] tx_cnt;
   logic [15:0] tx_shift;
   // bus write lands on the edge at which the master samples ack
   wire wb_req = WB_CYC & WB_STB;
   wire wb_wr = wb_req & WB_WE & WB_ACK;
   wire [6:0] wb_idx = {1'b0, WB_ADR[7:2]};
   wire spi_evt = tg_sync ^ tg_seen;
   wire spi_rd = spi_evt & ~frame[`ISC_SPI_RW];
   wire spi_wr = spi_evt & frame[`ISC_SPI_RW];
   wire [6:0] spi_idx = frame[14:8];
   // ----------------------------------------
   // functions
   // ----------------------------------------
   function automatic logic signed [15:0] avg2(input logic signed [15:0] a, input logic signed [15:0] b);
      logic signed [16:0] s;
      s = {a[15], a} + {b[15], b};
      return s[16:1];
   endfunction : avg2
   function automatic logic signed [33:0] dot3(input int r, input logic ling_tab,
      input isc_pkg::axis3_t v);
      logic signed [15:0] c0;
      logic signed [15:0] c1;
      logic signed [15:0] c2;
      c0 = ling_tab ? LING_G[3 * r] : GAIN_M[3 * r];
      c1 = ling_tab ? LING_G[3 * r + 1] : GAIN_M[3 * r + 1];
      c2 = ling_tab ? LING_G[3 * r + 2] : GAIN_M[3 * r + 2];
      return 34'(c0 * v.x) + 34'(c1 * v.y) + 34'(c2 * v.z);
   endfunction : dot3
   // one output row: scale/alignment, linear-g when enabled, then bias, saturated
   function automatic logic signed [15:0] corr_row(input int r, input isc_pkg::axis3_t w,
      input isc_pkg::axis3_t a, input logic ling);
      logic signed [33:0] t;
      t = dot3(r, 1'b0, w) + (ling ? dot3(r, 1'b1, a) : 34'sh0); // RULE_09 RULE_10
      t = (t >>> `ISC_Q_SHIFT) + 34'(BIAS_B[r]); // RULE_09
      if (t[33:15] != {19{t[15]}}) begin
         return {t[33], {15{~t[33]}}};
      end
      return t[15:0];
   endfunction : corr_row
   function automatic logic [15:0] reg_read(input logic [6:0] idx);
      unique case (idx)
         `ISC_IDX_IOFN: return io_fn;
         `ISC_IDX_CFG: return cfg;
         `ISC_IDX_SCALE: return sync_scale;
         `ISC_IDX_STATUS: return {14'h0000, test_pass, run_state == isc_pkg::ST_RUN};
         `ISC_IDX_COUNT: return sample_count;
         `ISC_IDX_GYRO_X: return GYRO_OUT.x;
         `ISC_IDX_GYRO_Y: return GYRO_OUT.y;
         `ISC_IDX_GYRO_Z: return GYRO_OUT.z;
         `ISC_IDX_ACC_X: return ACCEL_OUT.x;
         `ISC_IDX_ACC_Y: return ACCEL_OUT.y;
         `ISC_IDX_ACC_Z: return ACCEL_OUT.z;
         default: return `ISC_ZERO16;
      endcase
   endfunction : reg_read
   // bus write wins over a serial write to the same register in the same cycle
   function automatic logic [15:0] reg_next(input logic [15:0] cur, input logic [6:0] idx);
      logic [15:0] v;
      v = cur;
      if (spi_wr && spi_idx == idx) begin
         v[7:0] = frame[7:0];
      end
      if (wb_wr && wb_idx == idx) begin
         if (WB_SEL[0]) begin
            v[7:0] = WB_DAT_I[7:0];
         end
         if (WB_SEL[1]) begin
            v[15:8] = WB_DAT_I[15:8];
         end
      end
      return v;
   endfunction : reg_next
   // ----------------------------------------
   // decode
   // ----------------------------------------
   wire running = run_state == isc_pkg::ST_RUN;
   wire [3:0] clk_sel = io_fn[`ISC_IOFN_SEL_HI:`ISC_IOFN_SEL_LO]; // RULE_03
   wire mode_sync = clk_sel == `ISC_SEL_SYNC;
   wire mode_pps = clk_sel == `ISC_SEL_PPS;
   wire mode_int = !mode_sync && !mode_pps;
   wire ext_rise = ext_sync & ~ext_last;
   wire int_wrap = int_cnt == 12'(`ISC_INT_DIV - 1); // RULE_02
   wire [24:0] pps_sum = pps_acc + {9'h000, sync_scale};
   wire pps_hit = pps_last != 24'h000000 && pps_sum >= {1'b0, pps_last}; // RULE_08
   wire g1_wrap = g1_cnt == 12'(FIRST_DIV - 1);
   wire g2_wrap = g2_cnt == 12'(SECOND_DIV - 1);
   wire tick = running & ((mode_int & int_wrap) | (mode_sync & ext_rise) | (mode_pps & pps_hit)); // RULE_01 RULE_07
   wire ling = cfg[`ISC_CFG_LING]; // RULE_10
   wire isc_pkg::axis3_t combined = '{avg2(latest1.x, latest2.x), avg2(latest1.y, latest2.y),
      avg2(latest1.z, latest2.z)}; // RULE_05
   wire isc_pkg::axis3_t corrected = '{corr_row(0, comb_q, acc_q, ling), corr_row(1, comb_q, acc_q, ling),
      corr_row(2, comb_q, acc_q, ling)};
   wire [24:0] next_pps_acc = pps_hit ? pps_sum - {1'b0, pps_last} : pps_sum;
   wire spi_idle = SPI_CS_N | ~RESET_N;
   // ----------------------------------------
   // self test and registers
   // ----------------------------------------
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         run_state <= isc_pkg::ST_TEST;
         test_cnt <= 24'h000000;
         test_pass <= 1'b0;
         SELF_TEST_DONE <= 1'b0;
      end else begin
         unique case (run_state)
            isc_pkg::ST_TEST: begin
               test_cnt <= test_cnt + 24'h000001;
               if (test_cnt == 24'(SELF_TEST_CYCLES - 1)) begin
                  run_state <= isc_pkg::ST_RUN; // RULE_01
                  test_pass <= g1_seen & g2_seen;
                  SELF_TEST_DONE <= 1'b1;
               end
            end
            isc_pkg::ST_RUN: begin
               SELF_TEST_DONE <= 1'b1;
            end
         endcase
      end
   end
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         io_fn <= `ISC_IOFN_RST;
         cfg <= `ISC_CFG_RST;
         sync_scale <= `ISC_SCALE_RST;
         WB_ACK <= 1'b0;
         WB_DAT_O <= 32'h00000000;
      end else begin
         io_fn <= reg_next(io_fn, `ISC_IDX_IOFN);
         cfg <= reg_next(cfg, `ISC_IDX_CFG);
         sync_scale <= reg_next(sync_scale, `ISC_IDX_SCALE);
         WB_ACK <= wb_req & ~WB_ACK;
         WB_DAT_O <= {`ISC_ZERO16, reg_read(wb_idx)};
      end
   end
   // ----------------------------------------
   // sample master clock sources
   // ----------------------------------------
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         int_cnt <= 12'h000;
         ext_meta <= 1'b0;
         ext_sync <= 1'b0;
         ext_last <= 1'b0;
         pps_cnt <= 24'h000000;
         pps_last <= 24'h000000;
         pps_acc <= 25'h0000000;
      end else begin
         int_cnt <= int_wrap ? 12'h000 : int_cnt + 12'h001; // RULE_02
         ext_meta <= CONFIG_IO_LINE_1;
         ext_sync <= ext_meta;
         ext_last <= ext_sync;
         pps_cnt <= ext_rise ? 24'h000001 : (&pps_cnt ? pps_cnt : pps_cnt + 24'h000001);
         pps_last <= ext_rise ? pps_cnt : pps_last; // RULE_08
         pps_acc <= mode_pps ? next_pps_acc : 25'h0000000;
      end
   end
   // ----------------------------------------
   // gyro samplers, combine, correction
   // ----------------------------------------
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         g1_cnt <= 12'h000;
         g2_cnt <= 12'h000;
         g1_seen <= 1'b0;
         g2_seen <= 1'b0;
         latest1 <= '0;
         latest2 <= '0;
      end else begin
         g1_cnt <= g1_wrap ? 12'h000 : g1_cnt + 12'h001; // RULE_04
         g2_cnt <= g2_wrap ? 12'h000 : g2_cnt + 12'h001; // RULE_04
         g1_seen <= g1_seen | g1_wrap;
         g2_seen <= g2_seen | g2_wrap;
         latest1 <= g1_wrap ? AXIS_GYRO_FIRST : latest1;
         latest2 <= g2_wrap ? AXIS_GYRO_SECOND : latest2;
      end
   end
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         comb_q <= '0;
         acc_q <= '0;
         stage_v <= 1'b0;
         GYRO_OUT <= '0;
         ACCEL_OUT <= '0;
         SAMPLE_MASTER_CLOCK <= 1'b0;
         sample_count <= `ISC_ZERO16;
      end else begin
         comb_q <= tick ? combined : comb_q; // RULE_05
         acc_q <= tick ? ACCEL_RAW : acc_q; // RULE_06
         stage_v <= tick;
         GYRO_OUT <= stage_v ? corrected : GYRO_OUT; // RULE_16
         ACCEL_OUT <= stage_v ? acc_q : ACCEL_OUT; // RULE_16
         SAMPLE_MASTER_CLOCK <= tick;
         sample_count <= sample_count + {15'h0000, tick};
      end
   end
   // ----------------------------------------
   // spi link, serial clock domain
   // ----------------------------------------
   always_ff @(posedge SPI_SCLK or posedge spi_idle) begin
      if (spi_idle) begin
         rx_cnt <= 4'h0;
         rx_shift <= 15'h0000;
      end else begin
         rx_cnt <= rx_cnt + 4'h1;
         rx_shift <= {rx_shift[13:0], SPI_DIN}; // RULE_13 RULE_14
      end
   end
   // held frame outlives chip select; handed over by toggle
   always_ff @(posedge SPI_SCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         frame <= `ISC_ZERO16;
         frame_tgl <= 1'b0;
      end else if (!SPI_CS_N && rx_cnt == `ISC_SPI_LAST) begin
         frame <= {rx_shift, SPI_DIN}; // RULE_14
         frame_tgl <= ~frame_tgl;
      end
   end
   // reply_word is settled long before the next frame, so sampling it here is safe
   always_ff @(negedge SPI_SCLK or posedge spi_idle) begin
      if (spi_idle) begin
         tx_cnt <= 4'h0;
         tx_shift <= `ISC_ZERO16;
         SPI_DOUT <= 1'b0;
         SPI_DOUT_OE_N <= 1'b1; // RULE_15
      end else begin
         tx_cnt <= tx_cnt + 4'h1;
         SPI_DOUT_OE_N <= 1'b0;
         if (tx_cnt == 4'h0) begin
            SPI_DOUT <= reply_arm & reply_word[15]; // RULE_12 RULE_15
            tx_shift <= reply_arm ? {reply_word[14:0], 1'b0} : `ISC_ZERO16;
         end else begin
            SPI_DOUT <= tx_shift[15]; // RULE_12
            tx_shift <= {tx_shift[14:0], 1'b0};
         end
      end
   end
   // ----------------------------------------
   // spi requests, system domain
   // ----------------------------------------
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         tg_meta <= 1'b0;
         tg_sync <= 1'b0;
         tg_seen <= 1'b0;
         reply_word <= `ISC_ZERO16;
         reply_arm <= 1'b0;
      end else begin
         tg_meta <= frame_tgl;
         tg_sync <= tg_meta;
         tg_seen <= tg_sync;
         reply_word <= spi_rd ? reg_read(spi_idx) : reply_word;
         reply_arm <= spi_evt ? spi_rd : reply_arm; // RULE_15
      end
   end
   // ----------------------------------------
   // checks
   // ----------------------------------------
   logic [11:0] gap;
   logic last_tick_int;
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         gap <= 12'h000;
         last_tick_int <= 1'b0;
      end else begin
         gap <= tick ? 12'h000 : gap + 12'h001;
         last_tick_int <= tick ? mode_int : (last_tick_int & mode_int);
      end
   end
   AST_NO_TICK_IN_TEST: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      !running |-> ##1 !SAMPLE_MASTER_CLOCK) else $error("tick during self test"); // RULE_01
   AST_INT_RATE: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      tick && mode_int && last_tick_int |-> gap == 12'(`ISC_INT_DIV - 1)) else $error("internal rate wrong"); // RULE_02
   AST_SEL_WRITE: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      wb_wr && wb_idx == `ISC_IDX_IOFN && WB_SEL[0] |=> clk_sel == $past(WB_DAT_I[7:4]))
      else $error("clock select not written"); // RULE_03
   AST_GYRO_LATCH: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      g1_wrap |=> latest1 == $past(AXIS_GYRO_FIRST) ##1 $stable(latest1)) else $error("first gyro not latched"); // RULE_04
   AST_COMBINE: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      tick |=> comb_q == $past(combined) ##1 GYRO_OUT == $past(corrected)) else $error("combine path wrong"); // RULE_05
   AST_ACCEL_TICK: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      tick |-> ##2 ACCEL_OUT == $past(ACCEL_RAW, 2)) else $error("accel not on tick"); // RULE_06
   AST_SYNC_EDGE: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      running && mode_sync && ext_rise |=> SAMPLE_MASTER_CLOCK) else $error("sync edge lost"); // RULE_07
   AST_PPS_NEEDS_PERIOD: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      mode_pps && tick |-> pps_last != 24'h000000) else $error("pulse tick without period"); // RULE_08
   AST_LING_OFF: assert property (@(posedge SYS_CLK) disable iff (!RESET_N) // RULE_10
      stage_v && !ling |=> GYRO_OUT.x == corr_row(0, $past(comb_q), '0, 1'b1))
      else $error("linear g leaked");
   AST_HOLD: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      !stage_v |=> $stable(GYRO_OUT) && $stable(ACCEL_OUT)) else $error("output moved between ticks"); // RULE_16
   AST_DOUT_DRIVE: assert property (@(negedge SPI_SCLK) disable iff (spi_idle)
      tx_cnt != 4'h0 |-> !SPI_DOUT_OE_N) else $error("dout not driven in frame"); // RULE_12
   AST_DOUT_QUIET: assert property (@(negedge SPI_SCLK) disable iff (spi_idle)
      tx_cnt == 4'h1 && !reply_arm |-> !SPI_DOUT) else $error("data without read request"); // RULE_15
   COV_INT_TICK: cover property (@(posedge SYS_CLK) disable iff (!RESET_N) tick && mode_int);
   COV_SYNC_TICK: cover property (@(posedge SYS_CLK) disable iff (!RESET_N) tick && mode_sync);
   COV_PPS_TICK: cover property (@(posedge SYS_CLK) disable iff (!RESET_N) tick && mode_pps);
   COV_SPI_READ: cover property (@(posedge SYS_CLK) disable iff (!RESET_N) spi_rd ##[1:300] spi_evt);
endmodule : inertial_sample_chain

// *** test/spi_host_model.sv ***
// Purpose: spi master model for the sample chain readout port
// Assumes: mode 3 frames of 16 bits, msb first
// Notes: link clock stands still high between frames
`timescale 1ns/10ps
module spi_host_model (
   output logic sclk,
   output logic cs_n,
   output logic din,
   input wire logic dout,
   input wire logic dout_oe_n
);
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      din = 1'b0;
   end
   // ----------------------------------------
   // one frame, 32 ns link period
   // ----------------------------------------
   task automatic frame(input logic [15:0] tx, output logic [15:0] rx, output logic oe_ok);
      oe_ok = 1'b1;
      cs_n <= 1'b0;
      #32;
      for (int k = 15; k >= 0; k--) begin
         sclk <= 1'b0;
         din <= tx[k];
         #16;
         rx[k] = dout;
         oe_ok = oe_ok & (dout_oe_n === 1'b0);
         sclk <= 1'b1;
         #16;
      end
      #32;
      cs_n <= 1'b1;
      // released line must not show a stale bit
      din <= ~din;
      #5000;
   endtask : frame
endmodule : spi_host_model

// *** test/tb_inertial_sample_chain.sv ***
// Purpose: self-checking bench of the inertial sample chain
// Assumes: self test shortened to 2600 cycles, past the first sample of both samplers
// Notes: pulse-rate mode runs on the period of the bench's own sync-mode edges
`timescale 1ns/10ps
`include "isc_defs.svh"
module tb_inertial_sample_chain;
   logic sys_clk, reset_n, wb_cyc, wb_stb, wb_we, wb_ack, sclk, cs_n, din, dout, dout_oe_n;
   logic io_line, smc, st_done, early, ok;
   logic [7:0] wb_adr;
   logic [3:0] wb_sel;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [47:0] rd;
   logic [15:0] rx;
   isc_pkg::axis3_t g1, g2, acc, gyro_out, acc_out;
   int n_fail, num_checks, cyc;
   inertial_sample_chain #(.SELF_TEST_CYCLES(2600)) dut_u (
      .SYS_CLK(sys_clk), .RESET_N(reset_n), .WB_CYC(wb_cyc), .WB_STB(wb_stb), .WB_WE(wb_we),
      .WB_ADR(wb_adr), .WB_SEL(wb_sel), .WB_DAT_I(wb_dat_i), .WB_DAT_O(wb_dat_o), .WB_ACK(wb_ack),
      .SPI_SCLK(sclk), .SPI_CS_N(cs_n), .SPI_DIN(din), .SPI_DOUT(dout), .SPI_DOUT_OE_N(dout_oe_n),
      .CONFIG_IO_LINE_1(io_line), .AXIS_GYRO_FIRST(g1), .AXIS_GYRO_SECOND(g2), .ACCEL_RAW(acc),
      .GYRO_OUT(gyro_out), .ACCEL_OUT(acc_out), .SAMPLE_MASTER_CLOCK(smc), .SELF_TEST_DONE(st_done));
   spi_host_model spi_u (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe_n(dout_oe_n));
   // ----------------------------------------
   // reporting and bus tasks
   // ----------------------------------------
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : wrap_up
   task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic hang(input string what);
      n_fail++;
      $display("[FAIL] %s expected answer seen timeout", what);
      wrap_up();
   endtask : hang
   task automatic wb(input logic we, input logic [5:0] idx, input logic [15:0] wd);
      int n;
      n = 0;
      @(posedge sys_clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_sel <= 4'h3;
      wb_adr <= {idx, 2'b00};
      wb_dat_i <= {16'h0000, wd};
      do begin
         @(posedge sys_clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 20);
      if (n >= 20) hang("bus ack");
      rd = {16'h0000, wb_dat_o};
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask : wb
   task automatic wait_tick(input int lim);
      cyc = 0;
      do begin
         @(posedge sys_clk);
         cyc++;
      end while (smc !== 1'b1 && cyc < lim);
      if (cyc >= lim) hang("sample tick");
   endtask : wait_tick
   task automatic quiet(input string what);
      int n;
      n = 0;
      repeat (3000) begin
         @(posedge sys_clk);
         if (smc === 1'b1) n++;
      end
      check(what, n, 0);
   endtask : quiet
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs();
      wb(1'b0, 6'h00, 16'h0000);
      check("io function reset", rd, 48'h0);
      wb(1'b0, 6'h01, 16'h0000);
      check("config reset", rd, 48'h80);
      wb(1'b1, 6'h3F, 16'hFFFF);
      wb(1'b0, 6'h3F, 16'h0000);
      check("unmapped read", rd, 48'h0);
      wb(1'b1, 6'h04, 16'h1234);
      wb(1'b0, 6'h04, 16'h0000);
      check("tick count before test", rd, 48'h0);
   endtask : t_regs
   task automatic t_boot();
      int n;
      n = 0;
      while (st_done !== 1'b1 && n < 3000) begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= 3000) hang("self test");
      wait_tick(3000);
      check("tick before self test", early, 1'b0);
   endtask : t_boot
   task automatic t_rate();
      wait_tick(3000);
      check("internal tick period", cyc, `ISC_INT_DIV);
      repeat (3) @(posedge sys_clk);
      check("gyro corrected", gyro_out, {16'h00A6, 16'h0030, 16'h0030});
      check("accel at tick", acc_out, acc);
      g1.x <= 16'h0100;
      g2.x <= 16'h0200;
      repeat (2300) @(posedge sys_clk);
      check("held between ticks", gyro_out, {16'h00A6, 16'h0030, 16'h0030});
   endtask : t_rate
   task automatic t_ling();
      wb(1'b1, 6'h01, 16'h0000);
      wait_tick(3000);
      wait_tick(3000);
      repeat (3) @(posedge sys_clk);
      check("linear-g off", gyro_out, {16'h0180, 16'h0020, 16'h0030});
      wb(1'b1, 6'h01, 16'h0080);
   endtask : t_ling
   task automatic t_sync();
      // no input period measured yet, so pulse mode must stay silent
      wb(1'b1, 6'h00, 16'h0020);
      quiet("pulse mode without input");
      wb(1'b1, 6'h00, 16'h0010);
      wb(1'b0, 6'h00, 16'h0000);
      check("clock select", rd, 48'h10);
      repeat (2) begin
         io_line <= 1'b1;
         // edge must tick within a few cycles
         wait_tick(8);
         repeat (60) @(posedge sys_clk);
         io_line <= 1'b0;
         quiet("no tick without edge");
      end
      // sync edges stood 3064 cycles apart; scale 1 keeps that rate
      wb(1'b1, 6'h02, 16'h0001);
      wb(1'b1, 6'h00, 16'h0020);
      wait_tick(3200);
      wait_tick(3200);
      check("pulse mode period", cyc, 3064);
      wb(1'b1, 6'h00, 16'h0000);
      wb(1'b1, 6'h02, 16'h0FA0);
   endtask : t_sync
   task automatic t_spi();
      spi_u.frame(16'h0300, rx, ok);
      check("first frame reply", rx, 48'h0);
      spi_u.frame(16'h8234, rx, ok);
      check("status over spi", rx & 16'h0003, 48'h3);
      spi_u.frame(16'h0200, rx, ok);
      check("reply after write", rx, 48'h0);
      spi_u.frame(16'h0000, rx, ok);
      check("scale over spi", rx, 48'hF34);
      check("dout driven in frame", ok, 1'b1);
      check("dout released", {dout_oe_n, dout}, 2'b10);
      wb(1'b0, 6'h02, 16'h0000);
      check("spi write landed", rd, 48'hF34);
   endtask : t_spi
   // ----------------------------------------
   // clock, monitor, main sequence
   // ----------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (reset_n !== 1'b1) begin
         early <= 1'b0;
      end else if (smc === 1'b1 && st_done !== 1'b1) begin
         early <= 1'b1;
      end
   end
   initial begin
      reset_n = 1'b0;
      {wb_cyc, wb_stb, wb_we, io_line} = 4'h0;
      wb_adr = 8'h00;
      wb_sel = 4'h0;
      wb_dat_i = 32'h00000000;
      n_fail = 0;
      num_checks = 0;
      g1 = {16'h0064, 16'h0010, 16'h0020};
      g2 = {16'h00C8, 16'h0030, 16'h0040};
      acc = {16'h4000, 16'h4000, 16'h0000};
      repeat (6) @(posedge sys_clk);
      reset_n <= 1'b1;
      t_regs();
      t_boot();
      t_rate();
      t_ling();
      t_sync();
      t_spi();
      wrap_up();
   end
endmodule : tb_inertial_sample_chain
